// ==== isowr_defines.svh ====
// isowr_defines.svh: widths, limits and timing counts of the single-wire readout link
// assumes a 200 MHz core clock; times are held in their own unit, counts derived from them
`ifndef ISOWR_DEFINES_SVH
`define ISOWR_DEFINES_SVH

// ==========================================================
// clock and rounding
`define ISOWR_CLK_NS         5
`define ISOWR_UP(ns)         (((ns) + `ISOWR_CLK_NS - 1) / `ISOWR_CLK_NS)
`define ISOWR_DN(ns)         ((ns) / `ISOWR_CLK_NS)

// ==========================================================
// frame layout
`define ISOWR_CNT_W          14
`define ISOWR_FRAME_W        28
`define ISOWR_IR_HI          27
`define ISOWR_IR_LO          14
`define ISOWR_TEMP_HI        13
`define ISOWR_TEMP_LO        0
`define ISOWR_IDX_W          5
`define ISOWR_TMR_W          22
`define ISOWR_IR_MIN         14'h01FF
`define ISOWR_IR_MAX         14'h3E01

// ==========================================================
// sensor timing
`define ISOWR_SAMPLE_MAX_US  14600
`define ISOWR_SAMPLE_MAX_CYC `ISOWR_DN(`ISOWR_SAMPLE_MAX_US * 1000)
`define ISOWR_IRQ_PERIOD_US  16000
`define ISOWR_IRQ_PERIOD_CYC `ISOWR_DN(`ISOWR_IRQ_PERIOD_US * 1000)
`define ISOWR_DISCH_US       16000
`define ISOWR_DISCH_CYC      `ISOWR_DN(`ISOWR_DISCH_US * 1000)
`define ISOWR_IRQ_PULSE_NS   1000
`define ISOWR_IRQ_PULSE_CYC  `ISOWR_UP(`ISOWR_IRQ_PULSE_NS)
`define ISOWR_UPDATE_US      1250
`define ISOWR_UPDATE_CYC     `ISOWR_DN(`ISOWR_UPDATE_US * 1000)

// ==========================================================
// host timing
`define ISOWR_START_PULSE_US 110
`define ISOWR_START_CYC      `ISOWR_UP(`ISOWR_START_PULSE_US * 1000)
`define ISOWR_IRQ_SETUP_US   75
`define ISOWR_IRQ_SETUP_CYC  `ISOWR_UP(`ISOWR_IRQ_SETUP_US * 1000)
`define ISOWR_CLK_LOW_NS     1000
`define ISOWR_CLK_LOW_CYC    `ISOWR_UP(`ISOWR_CLK_LOW_NS)
`define ISOWR_CLK_HIGH_NS    1000
`define ISOWR_CLK_HIGH_CYC   `ISOWR_UP(`ISOWR_CLK_HIGH_NS)
`define ISOWR_BIT_MAX_US     25
`define ISOWR_SETTLE_MIN_US  2
`define ISOWR_SETTLE_US      5
`define ISOWR_SETTLE_CYC     `ISOWR_UP(`ISOWR_SETTLE_US * 1000)
`define ISOWR_HOST_UPD_US    1300
`define ISOWR_HOST_UPD_CYC   `ISOWR_UP(`ISOWR_HOST_UPD_US * 1000)
`define ISOWR_PERIOD_US      10000
`define ISOWR_PERIOD_CYC     `ISOWR_UP(`ISOWR_PERIOD_US * 1000)

`endif

// ==== isowr_pkg.sv ====
// isowr_pkg.sv: state types and shared helpers of the single-wire readout link
// assumes isowr_defines.svh is on the include path
`include "isowr_defines.svh"

package isowr_pkg;

  // ==========================================================
  // state types
  typedef enum logic [2:0] {DS_IDLE, DS_IRQ, DS_ARMED, DS_SHIFT} isowr_dev_state_t;
  typedef enum logic [2:0] {HS_IDLE, HS_FORCE, HS_IRQ_WAIT, HS_LOW, HS_HIGH, HS_SETTLE, HS_UPDATE}
    isowr_host_state_t;

  // ==========================================================
  // helpers
  function automatic logic isowr_rise(input logic prev, input logic cur);
    return !prev && cur;
  endfunction : isowr_rise

  function automatic logic isowr_fall(input logic prev, input logic cur);
    return prev && !cur;
  endfunction : isowr_fall

endpackage : isowr_pkg

// ==== isowr_link_if.sv ====
// isowr_link_if.sv: the shared data line between sensor end and host end
// assumes both ends run on the same core clock; a keeper holds the last level
`timescale 1ns/1ps
`default_nettype none

interface isowr_link_if (
  input wire logic clk,
  input wire logic rst_n
);
  logic host_drv;
  logic host_oe_n;
  logic dev_drv;
  logic dev_oe_n;
  logic keep;
  logic line;

  // wire level: host wins a clash, released line keeps its level
  assign line = !host_oe_n ? host_drv : (!dev_oe_n ? dev_drv : keep);

  // line keeper
  always_ff @(posedge clk)
  begin
    if (!rst_n) keep <= 1'b0;
    else        keep <= line;
  end

  modport dev  (input line, output dev_drv, output dev_oe_n);
  modport host (input line, output host_drv, output host_oe_n);
endinterface : isowr_link_if

`default_nettype wire

// ==== isowr_dev.sv ====
// isowr_dev.sv: sensor end of the single-wire readout link
// assumes samples arrive on the core clock; the line reaches this end from outside
`timescale 1ns/1ps
`default_nettype none
`include "isowr_defines.svh"

module isowr_dev
  import isowr_pkg::*;
#(
  parameter int unsigned IDLE_CYC   = `ISOWR_SAMPLE_MAX_CYC,
  parameter int unsigned PERIOD_CYC = `ISOWR_IRQ_PERIOD_CYC,
  parameter int unsigned DISCH_CYC  = `ISOWR_DISCH_CYC,
  parameter int unsigned UPD_CYC    = `ISOWR_UPDATE_CYC
)(
  // clock and reset
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_n_i,
  // link
  isowr_link_if.dev                     link,
  // filtered samples
  input  wire logic [`ISOWR_CNT_W-1:0]  ir_sample_i,
  input  wire logic [`ISOWR_CNT_W-1:0]  temp_sample_i,
  input  wire logic                     sample_valid_i,
  // status
  output logic                          discharge_o,
  output logic                          busy_o
);

  // ==========================================================
  // declarations
  isowr_dev_state_t           state;
  logic                       sync1;
  logic                       sync2;
  logic                       prev;
  logic                       rise;
  logic                       fall;
  logic                       drive_high;
  logic                       drive_low;
  logic                       remain;
  logic [`ISOWR_IDX_W-1:0]    idx;
  logic [`ISOWR_TMR_W-1:0]    tmr;
  logic [`ISOWR_TMR_W-1:0]    low_cnt;
  logic [`ISOWR_TMR_W-1:0]    dis_cnt;
  logic [`ISOWR_FRAME_W-1:0]  frame;
  logic [`ISOWR_CNT_W-1:0]    ir_last;
  logic [`ISOWR_CNT_W-1:0]    temp_last;
  logic                       refresh;

  // ==========================================================
  // line input synchroniser and edges
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      prev  <= 1'b0;
    end
    else
    begin
      sync1 <= link.line;
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  assign rise = isowr_rise(prev, sync2);
  assign fall = isowr_fall(prev, sync2);

  // line drivers come straight from registers
  assign link.dev_drv  = drive_high;
  assign link.dev_oe_n = !(drive_high || drive_low);
  assign busy_o        = (state != DS_IDLE);

  // time the line has been low inside a frame
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || state != DS_SHIFT || sync2) low_cnt <= '0;
    else if (low_cnt != '1)                     low_cnt <= low_cnt + 1'b1;
  end

  // long low ends a frame or an abort and refreshes the values
  assign refresh = (state == DS_SHIFT) && (low_cnt >= `ISOWR_TMR_W'(UPD_CYC - 1));

  // ==========================================================
  // link sequencer
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      state      <= DS_IDLE;
      tmr        <= '0;
      drive_high <= 1'b0;
      drive_low  <= 1'b0;
      remain     <= 1'b0;
      idx        <= '0;
    end
    else
    begin
      case (state)
        DS_IDLE:
        begin
          drive_low <= 1'b0;
          if (rise)
          begin
            state <= DS_ARMED;
            tmr   <= '0;
          end
          else if (tmr >= `ISOWR_TMR_W'(IDLE_CYC - 1))
          begin
            state      <= DS_IRQ;
            drive_high <= 1'b1;
            tmr        <= '0;
          end
          else tmr <= tmr + 1'b1;
        end
        DS_IRQ:
        begin
          // short high pulse, the keeper holds the level afterwards
          if (tmr >= `ISOWR_TMR_W'(`ISOWR_IRQ_PULSE_CYC - 1))
          begin
            state      <= DS_ARMED;
            drive_high <= 1'b0;
            tmr        <= '0;
          end
          else tmr <= tmr + 1'b1;
        end
        DS_ARMED:
        begin
          if (fall)
          begin
            state  <= DS_SHIFT;
            idx    <= `ISOWR_IDX_W'(`ISOWR_FRAME_W - 1);
            remain <= 1'b1;
          end
          else if (tmr >= `ISOWR_TMR_W'(PERIOD_CYC - 1))
          begin
            state      <= DS_IRQ;
            drive_high <= 1'b1;
            tmr        <= '0;
          end
          else tmr <= tmr + 1'b1;
        end
        DS_SHIFT:
        begin
          if (refresh)
          begin
            state     <= DS_IDLE;
            drive_low <= 1'b0;
            tmr       <= '0;
          end
          else if (rise)
          begin
            // zero pulls low, one leaves the line released
            drive_low <= remain && !frame[idx];
            if (idx == '0) remain <= 1'b0;
            else           idx    <= idx - 1'b1;
          end
        end
        default:
        begin
          state      <= DS_IDLE;
          drive_high <= 1'b0;
          drive_low  <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // latest samples and frame snapshot
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      ir_last   <= '0;
      temp_last <= '0;
      frame     <= '0;
    end
    else
    begin
      if (sample_valid_i)
      begin
        ir_last   <= ir_sample_i;
        temp_last <= temp_sample_i;
      end
      // frame only changes between transfers
      if (refresh || state == DS_IDLE)
        frame <= {ir_last, temp_last};
    end
  end

  // ==========================================================
  // out of range discharge of the sensing element
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      dis_cnt     <= '0;
      discharge_o <= 1'b0;
    end
    else if (sample_valid_i && (ir_sample_i < `ISOWR_IR_MIN || ir_sample_i > `ISOWR_IR_MAX))
    begin
      dis_cnt     <= `ISOWR_TMR_W'(DISCH_CYC - 1);
      discharge_o <= 1'b1;
    end
    else if (dis_cnt != '0) dis_cnt <= dis_cnt - 1'b1;
    else                    discharge_o <= 1'b0;
  end

endmodule : isowr_dev

`default_nettype wire

// ==== isowr_host.sv ====
// isowr_host.sv: host end of the single-wire readout link and its frame FIFO
// assumes the sensor end shares the line through isowr_link_if on the same core clock
`timescale 1ns/1ps
`default_nettype none
`include "isowr_defines.svh"

// ==========================================================
// frame FIFO
module isowr_fifo #(
  parameter int unsigned WIDTH = `ISOWR_FRAME_W,
  parameter int unsigned DEPTH = 32
)(
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  // fill side
  input  wire logic              in_valid_i,
  input  wire logic [WIDTH-1:0]  in_data_i,
  output logic                   in_ready_o,
  // drain side
  output logic                   out_valid_o,
  output logic [WIDTH-1:0]       out_data_o,
  input  wire logic              out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0]  mem [DEPTH];
  logic [AW:0]       wr_ptr;
  logic [AW:0]       rd_ptr;

  // full when pointers differ only in the wrap bit
  assign in_ready_o  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid_o = (wr_ptr != rd_ptr);
  assign out_data_o  = mem[rd_ptr[AW-1:0]];

  // storage
  always_ff @(posedge core_clk_i)
  begin
    if (in_valid_i && in_ready_o) mem[wr_ptr[AW-1:0]] <= in_data_i;
  end

  // pointers
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (in_valid_i && in_ready_o)   wr_ptr <= wr_ptr + 1'b1;
      if (out_valid_o && out_ready_i) rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule : isowr_fifo

// Overview of operation
// - frame is 28 bits: infrared high, temperature low
// - out of range infrared shorts input 16 ms
// - both values are 14-bit unsigned counts
// - every transfer opens with a rising line
// - forced start: high at least 110 us, then low
// - sensor raises line after 14.6 ms idle
// - sensor interrupt repeats about every 16 ms
// - host answers interrupt low, bits after 75 us
// - host stays released while awaiting interrupt
// - forced readout is the preferred mode
// - host rising edge, sensor holds zero low
// - host pulls low, rises again per bit
// - after bit 0 hold low over 1250 us
// - bit period and low time under 25 us
// - settle at least 2 us before sampling
// - whole frame read within 800 us
// - interrupt mode readout under 14.6 ms
// - long low aborts and refreshes anytime
// - host reads frames at equal intervals
module isowr_host
  import isowr_pkg::*;
#(
  parameter int unsigned START_CYC  = `ISOWR_START_CYC,
  parameter int unsigned SETUP_CYC  = `ISOWR_IRQ_SETUP_CYC,
  parameter int unsigned UPD_CYC    = `ISOWR_HOST_UPD_CYC,
  parameter int unsigned PERIOD_CYC = `ISOWR_PERIOD_CYC
)(
  // clock and reset
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_n_i,
  // link
  isowr_link_if.host                    link,
  // control
  input  wire logic                     enable_i,
  input  wire logic                     irq_mode_i,
  input  wire logic                     abort_i,
  // frames out
  output logic                          frame_valid_o,
  output logic [`ISOWR_CNT_W-1:0]       frame_ir_o,
  output logic [`ISOWR_CNT_W-1:0]       frame_temp_o,
  input  wire logic                     frame_ready_i,
  // status
  output logic                          busy_o
);

  // ==========================================================
  // declarations
  isowr_host_state_t          state;
  logic                       sync1;
  logic                       sync2;
  logic                       prev;
  logic                       drv_en;
  logic                       drv_val;
  logic                       abort_q;
  logic                       push;
  logic                       space;
  logic                       due;
  logic [`ISOWR_IDX_W-1:0]    nbits;
  logic [`ISOWR_TMR_W-1:0]    tmr;
  logic [`ISOWR_TMR_W-1:0]    ptmr;
  logic [`ISOWR_FRAME_W-1:0]  shreg;
  logic [`ISOWR_FRAME_W-1:0]  fifo_data;

  // ==========================================================
  // line input synchroniser
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      prev  <= 1'b0;
    end
    else
    begin
      sync1 <= link.line;
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  assign link.host_drv  = drv_val;
  assign link.host_oe_n = !drv_en;
  assign busy_o         = (state != HS_IDLE);
  assign due            = (ptmr >= `ISOWR_TMR_W'(PERIOD_CYC - 1));

  // ==========================================================
  // frame FIFO; a full FIFO holds off the next readout
  isowr_fifo #(
    .WIDTH (`ISOWR_FRAME_W),
    .DEPTH (32)
  ) isowr_fifo_inst (
    .core_clk_i  (core_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (push),
    .in_data_i   (shreg),
    .in_ready_o  (space),
    .out_valid_o (frame_valid_o),
    .out_data_o  (fifo_data),
    .out_ready_i (frame_ready_i)
  );

  assign frame_ir_o   = fifo_data[`ISOWR_IR_HI:`ISOWR_IR_LO];
  assign frame_temp_o = fifo_data[`ISOWR_TEMP_HI:`ISOWR_TEMP_LO];

  // sample interval timer, restarted at each forced readout start
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || (state == HS_FORCE && tmr == '0)) ptmr <= '0;
    else if (!due)                                     ptmr <= ptmr + 1'b1;
  end

  // abort request, a new request wins over the clear
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)                abort_q <= 1'b0;
    else if (abort_i)            abort_q <= 1'b1;
    else if (state == HS_IDLE)   abort_q <= 1'b0;
  end

  // ==========================================================
  // readout sequencer
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      state   <= HS_IDLE;
      tmr     <= '0;
      drv_en  <= 1'b0;
      drv_val <= 1'b0;
      nbits   <= '0;
      shreg   <= '0;
      push    <= 1'b0;
    end
    else
    begin
      push <= 1'b0;
      tmr  <= tmr + 1'b1;
      case (state)
        HS_IDLE:
        begin
          drv_en <= 1'b0;
          tmr    <= '0;
          nbits  <= '0;
          if (enable_i && space && irq_mode_i && isowr_rise(prev, sync2))
            state <= HS_IRQ_WAIT;
          else if (enable_i && space && !irq_mode_i && due)
          begin
            state   <= HS_FORCE;
            drv_en  <= 1'b1;
            drv_val <= 1'b1;
          end
        end
        HS_FORCE:
          if (tmr >= `ISOWR_TMR_W'(START_CYC - 1))
          begin
            state   <= HS_LOW;
            drv_val <= 1'b0;
            tmr     <= '0;
          end
        HS_IRQ_WAIT:
          if (tmr >= `ISOWR_TMR_W'(SETUP_CYC - 1))
          begin
            state   <= HS_LOW;
            drv_en  <= 1'b1;
            drv_val <= 1'b0;
            tmr     <= '0;
          end
        HS_LOW:
          // short low keeps each bit well inside its limit
          if (tmr >= `ISOWR_TMR_W'(`ISOWR_CLK_LOW_CYC - 1))
          begin
            state   <= HS_HIGH;
            drv_val <= 1'b1;
            tmr     <= '0;
          end
        HS_HIGH:
          if (tmr >= `ISOWR_TMR_W'(`ISOWR_CLK_HIGH_CYC - 1))
          begin
            state  <= HS_SETTLE;
            drv_en <= 1'b0;
            tmr    <= '0;
          end
        HS_SETTLE:
          if (tmr >= `ISOWR_TMR_W'(`ISOWR_SETTLE_CYC - 1))
          begin
            shreg   <= {shreg[`ISOWR_FRAME_W-2:0], sync2};
            nbits   <= nbits + 1'b1;
            drv_en  <= 1'b1;
            drv_val <= 1'b0;
            tmr     <= '0;
            if (nbits == `ISOWR_IDX_W'(`ISOWR_FRAME_W - 1) || abort_q)
              state <= HS_UPDATE;
            else
              state <= HS_LOW;
          end
        HS_UPDATE:
          if (tmr >= `ISOWR_TMR_W'(UPD_CYC - 1))
          begin
            state  <= HS_IDLE;
            drv_en <= 1'b0;
            push   <= (nbits == `ISOWR_IDX_W'(`ISOWR_FRAME_W)) && !abort_q;
          end
        default:
        begin
          state  <= HS_IDLE;
          drv_en <= 1'b0;
        end
      endcase
    end
  end

endmodule : isowr_host

`default_nettype wire

// ==== isowr_link_asserts.sv ====
// isowr_link_asserts.sv: timing checks on the shared line between sensor end and host end
// assumes plain copies of the link signals, all on the one core clock
`timescale 1ns/1ps
`default_nettype none

// defaults follow the bench's timer settings
module isowr_link_asserts #(
  parameter int unsigned IDLE_CYC  = 2000,
  parameter int unsigned DUPD_CYC  = 1500,
  parameter int unsigned HUPD_CYC  = 1600,
  parameter int unsigned START_CYC = 22000
)(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // line drivers and level
  input  wire logic host_drv,
  input  wire logic host_oe_n,
  input  wire logic dev_drv,
  input  wire logic dev_oe_n,
  input  wire logic line
);
  // ==========================================================
  // helper run lengths
  logic        irq;
  logic        line_q;
  logic [15:0] quiet_cnt;
  logic [15:0] rise_cnt;
  logic [15:0] irq_cnt;
  logic [15:0] hi_cnt;
  logic [15:0] lo_cnt;
  logic [15:0] rel_cnt;

  // sensor drives high only as its interrupt
  assign irq = !dev_oe_n && dev_drv;

  // saturating run length, cleared when the run breaks
  function automatic logic [15:0] run(input logic c, input logic [15:0] n);
    return c ? n + {15'h0000, ~&n} : 16'h0000;
  endfunction : run

  // run lengths of line and driver states
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      line_q    <= 1'b0;
      quiet_cnt <= 16'h0000;
      rise_cnt  <= 16'h0000;
      irq_cnt   <= 16'h0000;
      hi_cnt    <= 16'h0000;
      lo_cnt    <= 16'h0000;
      rel_cnt   <= 16'h0000;
    end
    else
    begin
      line_q    <= line;
      quiet_cnt <= run(line == line_q, quiet_cnt);
      rise_cnt  <= run(!(line && !line_q), rise_cnt);
      irq_cnt   <= run(irq, irq_cnt);
      hi_cnt    <= run(!host_oe_n && host_drv, hi_cnt);
      lo_cnt    <= run(!host_oe_n && !host_drv, lo_cnt);
      rel_cnt   <= run(host_oe_n, rel_cnt);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // sensor end
  property p_zero_after_rise;
    $fell(dev_oe_n) && !dev_drv |-> rise_cnt inside {[16'h0001:16'h0006]};
  endproperty
  a_zero_after_rise: assert property (p_zero_after_rise)
    else $error("sensor zero not tied to a host rise");

  property p_refresh_release;
    lo_cnt > DUPD_CYC + 8 |-> dev_oe_n;
  endproperty
  a_refresh_release: assert property (p_refresh_release)
    else $error("sensor still drives after long low");

  property p_idle_irq;
    $rose(irq) |-> quiet_cnt >= IDLE_CYC - 8;
  endproperty
  a_idle_irq: assert property (p_idle_irq)
    else $error("interrupt before idle time");

  property p_irq_len;
    $fell(irq) |-> $past(irq_cnt) inside {[16'h00BE:16'h00C9]};
  endproperty
  a_irq_len: assert property (p_irq_len)
    else $error("interrupt pulse length wrong");

  // ==========================================================
  // host end
  property p_host_start;
    $fell(host_drv) && !$past(host_oe_n) |-> $past(hi_cnt) >= START_CYC - 1;
  endproperty
  a_host_start: assert property (p_host_start)
    else $error("host high drive too short");

  property p_host_hold;
    $rose(host_oe_n) && !$past(host_drv) |-> $past(lo_cnt) >= HUPD_CYC - 1;
  endproperty
  a_host_hold: assert property (p_host_hold)
    else $error("host update low too short");

  property p_host_settle;
    $fell(host_oe_n) && !host_drv |-> $past(rel_cnt) >= 16'h0190;
  endproperty
  a_host_settle: assert property (p_host_settle)
    else $error("host bit settle too short");

  property p_host_quiet_irq;
    $rose(irq) |-> host_oe_n [*8];
  endproperty
  a_host_quiet_irq: assert property (p_host_quiet_irq)
    else $error("host drives during interrupt");
endmodule : isowr_link_asserts

`default_nettype wire

// ==== isowr_tb_top.sv ====
// isowr_tb_top.sv: sensor end and host end face each other; bench drives samples and host controls
// assumes design files and the line checker are compiled first
`timescale 1ns/1ps
`default_nettype none

module isowr_tb_top;
  // ==========================================================
  // stimulus and observation
  localparam logic [3:0][13:0] DIS_VAL = {14'h3E02, 14'h3E01, 14'h01FF, 14'h01FE};
  localparam logic [3:0]       DIS_HIT = 4'h9;

  logic        core_clk_i;
  logic        rst_n_i;
  logic [13:0] ir_sample;
  logic [13:0] temp_sample;
  logic        sample_valid;
  logic        discharge;
  logic        dev_busy;
  logic        enable;
  logic        irq_mode;
  logic        abort;
  logic        frame_valid;
  logic [13:0] frame_ir;
  logic [13:0] frame_temp;
  logic        frame_ready;
  logic        host_busy;
  int          miscompares;
  int          comparisons;

  // 200 MHz core clock
  initial core_clk_i = 1'b0;
  always #2.5 core_clk_i = ~core_clk_i;

  // ==========================================================
  // both ends on one line, checker beside it
  isowr_link_if isowr_link_if_inst (.clk(core_clk_i), .rst_n(rst_n_i));

  // shortened timers; sensor refresh must exceed the 1200-cycle low of a zero bit
  isowr_dev #(.IDLE_CYC(2000), .DISCH_CYC(500), .UPD_CYC(1500)) isowr_dev_inst (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .link(isowr_link_if_inst), .ir_sample_i(ir_sample),
    .temp_sample_i(temp_sample), .sample_valid_i(sample_valid), .discharge_o(discharge), .busy_o(dev_busy));

  isowr_host #(.UPD_CYC(1600), .PERIOD_CYC(100)) isowr_host_inst (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .link(isowr_link_if_inst), .enable_i(enable),
    .irq_mode_i(irq_mode), .abort_i(abort), .frame_valid_o(frame_valid), .frame_ir_o(frame_ir),
    .frame_temp_o(frame_temp), .frame_ready_i(frame_ready), .busy_o(host_busy));

  isowr_link_asserts isowr_link_asserts_inst (
    .clk(core_clk_i), .rst_n(rst_n_i), .host_drv(isowr_link_if_inst.host_drv),
    .host_oe_n(isowr_link_if_inst.host_oe_n), .dev_drv(isowr_link_if_inst.dev_drv),
    .dev_oe_n(isowr_link_if_inst.dev_oe_n), .line(isowr_link_if_inst.line));

  // ==========================================================
  // shared tasks
  task automatic check(input logic [27:0] seen, input logic [27:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic cycles(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : cycles

  // bounded wait for a level
  task automatic wait_level(ref logic sig, input logic lvl, input int limit);
    int n;
    n = 0;
    while (sig !== lvl && n < limit)
    begin
      cycles(1);
      n++;
    end
    // a wait that runs out counts as a mismatch
    if (sig !== lvl) miscompares++;
  endtask : wait_level

  task automatic test_done();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  // ==========================================================
  // scenarios
  // full forced frame, word lands in the fifo and pops
  task automatic forced_frame();
    enable = 1'b1;
    wait_level(host_busy, 1'b1, 300);
    // one forced readout only
    enable = 1'b0;
    wait_level(host_busy, 1'b0, 64000);
    cycles(3);
    check(28'(frame_valid), 28'h1);
    check({frame_ir, frame_temp}, {14'h2A5C, 14'h1357});
    check(28'(dev_busy), 28'h0);
    irq_mode = 1'b1;
    frame_ready = 1'b1;
    cycles(1);
    frame_ready = 1'b0;
    cycles(2);
    check(28'(frame_valid), 28'h0);
  endtask : forced_frame

  // sensor interrupt answered, abort raised during the setup wait ends the frame after its first bit
  task automatic irq_abort();
    enable = 1'b1;
    wait_level(dev_busy, 1'b1, 3000);
    check(28'(dev_busy), 28'h1);
    check(28'(isowr_link_if_inst.line), 28'h1);
    cycles(3000);
    check(28'(host_busy), 28'h1);
    abort = 1'b1;
    irq_mode = 1'b0;
    enable = 1'b0;
    cycles(1);
    abort = 1'b0;
    wait_level(host_busy, 1'b0, 16000);
    cycles(3);
    check(28'({host_busy, dev_busy, frame_valid}), 28'h0);
  endtask : irq_abort

  // range limits around the discharge thresholds
  task automatic discharge_table();
    for (int i = 0; i < 4; i++)
    begin
      ir_sample = DIS_VAL[i];
      sample_valid = 1'b1;
      cycles(1);
      sample_valid = 1'b0;
      cycles(1);
      check(28'(discharge), 28'(DIS_HIT[i]));
      cycles(496);
      check(28'(discharge), 28'(DIS_HIT[i]));
      cycles(6);
      check(28'(discharge), 28'h0);
    end
  endtask : discharge_table

  // ==========================================================
  // main sequence
  initial
  begin
    rst_n_i = 1'b0;
    enable = 1'b0;
    irq_mode = 1'b0;
    abort = 1'b0;
    frame_ready = 1'b0;
    ir_sample = 14'h2A5C;
    temp_sample = 14'h1357;
    sample_valid = 1'b0;
    miscompares = 0;
    comparisons = 0;
    cycles(10);
    rst_n_i = 1'b1;
    sample_valid = 1'b1;
    cycles(1);
    sample_valid = 1'b0;
    forced_frame();
    irq_abort();
    discharge_table();
    test_done();
  end

  // watchdog over the whole run
  initial
  begin
    repeat (100000) @(posedge core_clk_i);
    miscompares++;
    test_done();
  end
endmodule : isowr_tb_top

`default_nettype wire
